// file: src/ucfg_endpoint_cfg.sv
// endpoint configuration registers, ram allocation and packet completion
//
// Behaviour
// - endpoint zero is always control and enabled by firmware
// - one 4 KB ram shared; endpoint zero plus banks times size
// - allocation flag set only when size and banks fit
// - endpoints above zero may be bulk, interrupt or isochronous
// - packets up to the configured size accepted, larger refused
// - endpoint block repeats across a 64 KB logical window
// - auto-validate moves to the next bank without firmware
// - IN endpoint with transmit interrupt flags each sent packet
// - OUT endpoint with receive interrupt flags each stored packet
// - control transfer: setup, optional data, opposite status
// - status transactions handled like data of same direction
// - each endpoint handles all transactions of its type
// - seven endpoints; bank limits 1, 2, 2, 3, 3, 3, 3
`timescale 1ns/100ps
module ucfg_endpoint_cfg
  import ucfg_pkg::*;
(
  input  wire logic              clk_sys,
  input  wire logic              reset_n,
  input  wire logic [31:0]       s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [31:0]       s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  input  wire logic              xferDone,
  input  wire logic [EP_W-1:0]   xferEp,
  input  wire logic              xferIn,
  input  wire logic [LEN_W-1:0]  xferLen,
  output logic                   xferAccept_r,
  output logic                   xferRefuse_r,
  input  wire logic              winValid,
  input  wire logic [EP_W-1:0]   winEp,
  input  wire logic [WIN_AW-1:0] winAddr,
  output logic                   physValid_r,
  output logic [RAM_AW-1:0]      physAddr_r,
  output logic [NUM_EP-1:0]      epEvent_r
);

  // ****************************************
  // endpoint state
  // ****************************************
  logic [NUM_EP-1:0][CODE_W-1:0] sizeCode_r;
  logic [NUM_EP-1:0]             dirIn_r;
  logic [NUM_EP-1:0][1:0]        xtype_r;
  logic [NUM_EP-1:0][BANK_W-1:0] banks_r;
  logic [NUM_EP-1:0][1:0]        nTrans_r;
  logic [NUM_EP-1:0]             active_r;
  logic [NUM_EP-1:0]             autoVal_r;
  logic [NUM_EP-1:0]             txIrqEn_r;
  logic [NUM_EP-1:0]             rxIrqEn_r;
  logic [NUM_EP-1:0]             txDone_r;
  logic [NUM_EP-1:0]             rxFull_r;
  logic [NUM_EP-1:0][BANK_W-1:0] bankPtr_r;
  logic [NUM_EP-1:0]             mapOk;
  logic [NUM_EP-1:0][RAM_AW-1:0] epBase;

  // ****************************************
  // axi4-lite write side
  // ****************************************
  logic [31:0] awAddr_r;
  logic        awHave_r;
  logic [31:0] wData_r;
  logic [3:0]  wStrb_r;
  logic        wHave_r;
  logic        doWrite;
  logic [EP_W-1:0] wrEp;
  logic [3:0]  wrReg;
  logic        wrHit;

  assign doWrite = awHave_r && wHave_r && !s_axi_bvalid;
  assign wrEp    = awAddr_r[6:4];
  assign wrReg   = awAddr_r[3:0];
  assign wrHit   = (awAddr_r[31:7] == '0) && (wrEp < EP_W'(NUM_EP));

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      awHave_r      <= 1'b0;
      awAddr_r      <= '0;
      s_axi_awready <= 1'b1;
    end else if (s_axi_awvalid && s_axi_awready) begin
      awHave_r      <= 1'b1;
      awAddr_r      <= s_axi_awaddr;
      s_axi_awready <= 1'b0;
    end else if (s_axi_bvalid && s_axi_bready) begin
      awHave_r      <= 1'b0;
      s_axi_awready <= 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      wHave_r      <= 1'b0;
      wData_r      <= '0;
      wStrb_r      <= '0;
      s_axi_wready <= 1'b1;
    end else if (s_axi_wvalid && s_axi_wready) begin
      wHave_r      <= 1'b1;
      wData_r      <= s_axi_wdata;
      wStrb_r      <= s_axi_wstrb;
      s_axi_wready <= 1'b0;
    end else if (s_axi_bvalid && s_axi_bready) begin
      wHave_r      <= 1'b0;
      s_axi_wready <= 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else if (doWrite) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wrHit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ****************************************
  // register effects
  // ****************************************
  logic [NUM_EP-1:0] cfgWr;
  logic [NUM_EP-1:0] ctlWr;
  logic [NUM_EP-1:0] setWr;
  logic [NUM_EP-1:0] staWr;
  logic [NUM_EP-1:0] doneHit;
  logic              lenOk;
  logic              epOk;

  assign epOk  = xferEp < EP_W'(NUM_EP);
  assign lenOk = epOk && (xferLen <= LEN_W'(
                 (LEN_W'(1) << (sizeCode_r[xferEp] + SIZE_SHIFT))));
  genvar i;
  generate
    for (i = 0; i < NUM_EP; i++) begin : g_ep
      logic isIn;
      // bytes 0 and 1 carry every field; byte 3 holds only the read flag
      assign cfgWr[i] = doWrite && wrHit && (wrEp == EP_W'(i))
                        && (wrReg == REG_CFG) && wStrb_r[0];
      assign ctlWr[i] = doWrite && wrHit && (wrEp == EP_W'(i))
                        && (wrReg == REG_CTL) && wStrb_r[0];
      assign setWr[i] = doWrite && wrHit && (wrEp == EP_W'(i))
                        && (wrReg == REG_CTLSET) && wStrb_r[0];
      assign staWr[i] = doWrite && wrHit && (wrEp == EP_W'(i))
                        && (wrReg == REG_STAT) && wStrb_r[0];
      // completion on an active mapped endpoint
      assign doneHit[i] = xferDone && (xferEp == EP_W'(i)) && active_r[i]
                          && mapOk[i] && lenOk;
      // status stages follow the data path
      assign isIn = (xtype_r[i] == TYPE_CTRL) ? xferIn : dirIn_r[i];

      always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
          sizeCode_r[i] <= (i == 0) ? EP0_SIZE_CODE : '0;
          dirIn_r[i]    <= 1'b0;
          xtype_r[i]    <= TYPE_CTRL;
          banks_r[i]    <= (i == 0) ? ONE_BANK : '0;
          nTrans_r[i]   <= '0;
        end else if (cfgWr[i] && (i != 0)) begin
          sizeCode_r[i] <= wData_r[CFG_SIZE_LSB +: CODE_W];
          dirIn_r[i]    <= wData_r[CFG_DIR_BIT];
          xtype_r[i]    <= wData_r[CFG_TYPE_LSB +: 2];
          banks_r[i]    <= wData_r[CFG_BANK_LSB +: BANK_W];
          nTrans_r[i]   <= wStrb_r[1] ? wData_r[CFG_NTR_LSB +: 2]
                                      : nTrans_r[i];
        end
      end

      always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
          active_r[i]  <= 1'b0;
          autoVal_r[i] <= 1'b0;
          txIrqEn_r[i] <= 1'b0;
          rxIrqEn_r[i] <= 1'b0;
        end else if (ctlWr[i]) begin
          // endpoint zero enabled only by firmware
          active_r[i]  <= wData_r[CTL_ACT_BIT];
          autoVal_r[i] <= wData_r[CTL_AUTO_BIT];
          txIrqEn_r[i] <= wData_r[CTL_TXI_BIT];
          rxIrqEn_r[i] <= wData_r[CTL_RXI_BIT];
        end else if (setWr[i]) begin
          active_r[i]  <= active_r[i] | wData_r[CTL_ACT_BIT];
          autoVal_r[i] <= autoVal_r[i] | wData_r[CTL_AUTO_BIT];
          txIrqEn_r[i] <= txIrqEn_r[i] | wData_r[CTL_TXI_BIT];
          rxIrqEn_r[i] <= rxIrqEn_r[i] | wData_r[CTL_RXI_BIT];
        end
      end

      // flags: a new packet wins over a clear in the same cycle
      always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
          txDone_r[i] <= 1'b0;
          rxFull_r[i] <= 1'b0;
        end else begin
          txDone_r[i] <= (doneHit[i] && isIn) ||
                         (txDone_r[i] && !(staWr[i] && wData_r[STA_TX_BIT]));
          rxFull_r[i] <= (doneHit[i] && !isIn) ||
                         (rxFull_r[i] && !(staWr[i] && wData_r[STA_RX_BIT]));
        end
      end

      always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
          bankPtr_r[i] <= '0;
        end else if ((doneHit[i] && autoVal_r[i]) ||
                     (staWr[i] && wData_r[STA_VAL_BIT])) begin
          bankPtr_r[i] <= (bankPtr_r[i] + ONE_BANK >= banks_r[i]) ? '0
                          : bankPtr_r[i] + ONE_BANK;
        end
      end

      always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
          epEvent_r[i] <= 1'b0;
        end else begin
          epEvent_r[i] <= (txDone_r[i] && txIrqEn_r[i]) ||
                          (rxFull_r[i] && rxIrqEn_r[i]);
        end
      end
    end
  endgenerate

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      xferAccept_r <= 1'b0;
      xferRefuse_r <= 1'b0;
    end else begin
      xferAccept_r <= |doneHit;
      xferRefuse_r <= xferDone && !(|doneHit);
    end
  end

  // ****************************************
  // axi4-lite read side
  // ****************************************
  logic [EP_W-1:0] rdEp;
  logic [3:0]      rdReg;
  logic            rdHit;
  logic [31:0]     rdWord;

  assign rdEp  = s_axi_araddr[6:4];
  assign rdReg = s_axi_araddr[3:0];
  assign rdHit = (s_axi_araddr[31:7] == '0) && (rdEp < EP_W'(NUM_EP));
  always_comb begin
    rdWord = '0;
    if (rdHit) begin
      unique case (rdReg)
        REG_CFG: begin
          rdWord[CFG_SIZE_LSB +: CODE_W] = sizeCode_r[rdEp];
          rdWord[CFG_DIR_BIT]            = dirIn_r[rdEp];
          rdWord[CFG_TYPE_LSB +: 2]      = xtype_r[rdEp];
          rdWord[CFG_BANK_LSB +: BANK_W] = banks_r[rdEp];
          rdWord[CFG_NTR_LSB +: 2]       = nTrans_r[rdEp];
          rdWord[CFG_MAPD_BIT]           = mapOk[rdEp];
        end
        REG_CTL: begin
          rdWord[CTL_ACT_BIT]  = active_r[rdEp];
          rdWord[CTL_AUTO_BIT] = autoVal_r[rdEp];
          rdWord[CTL_TXI_BIT]  = txIrqEn_r[rdEp];
          rdWord[CTL_RXI_BIT]  = rxIrqEn_r[rdEp];
        end
        REG_STAT: begin
          rdWord[STA_TX_BIT]             = txDone_r[rdEp];
          rdWord[STA_RX_BIT]             = rxFull_r[rdEp];
          rdWord[STA_BANK_LSB +: BANK_W] = bankPtr_r[rdEp];
        end
        default: rdWord = '0;
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= rdWord;
      s_axi_rresp   <= rdHit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
    end
  end

  // ****************************************
  // allocation and window
  // ****************************************
  // shared ram total
  ucfg_alloc u_alloc (
    .sizeCode (sizeCode_r),
    .banks    (banks_r),
    .mapOk    (mapOk),
    .epBase   (epBase)
  );

  ucfg_remap u_remap (
    .clk_sys     (clk_sys),
    .reset_n     (reset_n),
    .reqValid    (winValid),
    .reqEp       (winEp),
    .reqAddr     (winAddr),
    .epBase      (epBase),
    .sizeCode    (sizeCode_r),
    .banks       (banks_r),
    .physValid_r (physValid_r),
    .physAddr_r  (physAddr_r)
  );

endmodule

// file: common/ucfg_pkg.sv
// shared constants and types for the endpoint configuration block
package ucfg_pkg;

  // ****************************************
  // sizes
  // ****************************************
  localparam int NUM_EP     = 7;
  localparam int EP_W       = 3;
  localparam int RAM_BYTES  = 4096;
  localparam int RAM_AW     = 12;
  localparam int WIN_AW     = 16;
  localparam int CODE_W     = 3;
  localparam int BANK_W     = 2;
  localparam int LEN_W      = 11;
  localparam int SUM_W      = 15;
  localparam int SIZE_SHIFT = 3;

  // ****************************************
  // register map: endpoint n at n*EP_STRIDE
  // ****************************************
  localparam logic [7:0] EP_STRIDE  = 8'h10;
  localparam logic [3:0] REG_CFG    = 4'h0;
  localparam logic [3:0] REG_CTL    = 4'h4;
  localparam logic [3:0] REG_CTLSET = 4'h8;
  localparam logic [3:0] REG_STAT   = 4'hc;

  // ****************************************
  // fields
  // ****************************************
  localparam int CFG_SIZE_LSB = 0;
  localparam int CFG_DIR_BIT  = 3;
  localparam int CFG_TYPE_LSB = 4;
  localparam int CFG_BANK_LSB = 6;
  localparam int CFG_NTR_LSB  = 8;
  localparam int CFG_MAPD_BIT = 31;
  localparam int CTL_ACT_BIT  = 0;
  localparam int CTL_AUTO_BIT = 1;
  localparam int CTL_TXI_BIT  = 2;
  localparam int CTL_RXI_BIT  = 3;
  localparam int STA_TX_BIT   = 0;
  localparam int STA_RX_BIT   = 1;
  localparam int STA_VAL_BIT  = 2;
  localparam int STA_BANK_LSB = 4;

  localparam logic [CODE_W-1:0] EP0_SIZE_CODE = 3'h3;
  localparam logic [BANK_W-1:0] ONE_BANK      = 2'h1;
  localparam logic [1:0]        RESP_OKAY     = 2'h0;
  localparam logic [1:0]        RESP_SLVERR   = 2'h2;

  typedef enum logic [1:0] {
    TYPE_CTRL = 2'h0,
    TYPE_ISO  = 2'h1,
    TYPE_BULK = 2'h2,
    TYPE_INT  = 2'h3
  } ucfg_xtype_t;

  localparam logic [NUM_EP-1:0][BANK_W-1:0] EP_MAX_BANKS =
    {2'h3, 2'h3, 2'h3, 2'h3, 2'h2, 2'h2, 2'h1};

endpackage

// file: src/ucfg_alloc.sv
// packet ram allocation check and base address of each endpoint block
`timescale 1ns/100ps
module ucfg_alloc
  import ucfg_pkg::*;
(
  input  wire logic [NUM_EP-1:0][CODE_W-1:0] sizeCode,
  input  wire logic [NUM_EP-1:0][BANK_W-1:0] banks,
  output logic      [NUM_EP-1:0]             mapOk,
  output logic      [NUM_EP-1:0][RAM_AW-1:0] epBase
);

  logic [NUM_EP:0][SUM_W-1:0] cum;

  assign cum[0] = '0;

  genvar i;
  generate
    for (i = 0; i < NUM_EP; i++) begin : g_ep
      logic [SUM_W-1:0] need;
      assign need = SUM_W'(banks[i]) << (sizeCode[i] + SIZE_SHIFT);
      assign cum[i+1] = cum[i] + need;
      assign epBase[i] = cum[i][RAM_AW-1:0];
      assign mapOk[i] = (banks[i] != '0) && (banks[i] <= EP_MAX_BANKS[i])
                        && (cum[i+1] <= SUM_W'(RAM_BYTES));
    end
  endgenerate

endmodule

// file: src/ucfg_remap.sv
// folds a 64 KB logical window address onto an endpoint's ram block
`timescale 1ns/100ps
module ucfg_remap
  import ucfg_pkg::*;
(
  input  wire logic                             clk_sys,
  input  wire logic                             reset_n,
  input  wire logic                             reqValid,
  input  wire logic [EP_W-1:0]                  reqEp,
  input  wire logic [WIN_AW-1:0]                reqAddr,
  input  wire logic [NUM_EP-1:0][RAM_AW-1:0]    epBase,
  input  wire logic [NUM_EP-1:0][CODE_W-1:0]    sizeCode,
  input  wire logic [NUM_EP-1:0][BANK_W-1:0]    banks,
  output logic                                  physValid_r,
  output logic      [RAM_AW-1:0]                physAddr_r
);

  logic [SUM_W-1:0]  blockLen;
  logic [WIN_AW-1:0] offset;
  logic              epOk;

  assign epOk = reqEp < EP_W'(NUM_EP);

  always_comb begin
    blockLen = '0;
    if (epOk) begin
      blockLen = SUM_W'(banks[reqEp]) << (sizeCode[reqEp] + SIZE_SHIFT);
    end
  end

  // block repeats across window
  // modulo keeps three-bank blocks contiguous at the cost of a divider
  assign offset = (blockLen == '0) ? '0
                  : WIN_AW'({1'b0, reqAddr} % {1'b0, blockLen});

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      physValid_r <= 1'b0;
      physAddr_r  <= '0;
    end else begin
      physValid_r <= reqValid && epOk && (blockLen != '0);
      physAddr_r  <= epOk ? epBase[reqEp] + offset[RAM_AW-1:0] : '0;
    end
  end

endmodule

// file: testbench/ucfg_cfg_assertions.sv
// port-level assertions for the endpoint configuration block
`timescale 1ns/100ps
module ucfg_cfg_assertions
  import ucfg_pkg::*;
(
  input logic                clk_sys,
  input logic                reset_n,
  input logic                s_axi_awvalid,
  input logic                s_axi_awready,
  input logic                s_axi_wvalid,
  input logic                s_axi_wready,
  input logic [1:0]          s_axi_bresp,
  input logic                s_axi_bvalid,
  input logic                s_axi_bready,
  input logic                s_axi_arvalid,
  input logic                s_axi_arready,
  input logic [31:0]         s_axi_rdata,
  input logic                s_axi_rvalid,
  input logic                s_axi_rready,
  input logic                xferDone,
  input logic [EP_W-1:0]     xferEp,
  input logic [LEN_W-1:0]    xferLen,
  input logic                xferAccept_r,
  input logic                xferRefuse_r,
  input logic                winValid,
  input logic [EP_W-1:0]     winEp,
  input logic [WIN_AW-1:0]   winAddr,
  input logic                physValid_r,
  input logic [RAM_AW-1:0]   physAddr_r
);
  default clocking @(posedge clk_sys);
  endclocking
  default disable iff (!reset_n);

  // ****************************************
  // sequences
  // ****************************************
  sequence wrTaken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence xferSeen;
    xferDone;
  endsequence

  // ****************************************
  // properties
  // ****************************************
  a_write_resp_delay: assert property (
    wrTaken |=> !s_axi_bvalid ##1 s_axi_bvalid)
    else $error("write response not two cycles after address and data");
  a_bresp_hold: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped before bready");
  a_aw_blocked: assert property (
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("new write taken while response pending");
  a_read_resp_next: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
    else $error("read data not one cycle after address");
  a_rdata_hold: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data changed before rready");
  a_xfer_one_result: assert property (
    xferSeen |=> xferAccept_r ^ xferRefuse_r)
    else $error("transfer without exactly one verdict");
  a_xfer_no_spurious: assert property (
    !xferDone |=> !xferAccept_r && !xferRefuse_r)
    else $error("verdict without a transfer");
  a_xfer_oversize: assert property (
    xferSeen ##0 xferLen > 11'd1024 |=> xferRefuse_r)
    else $error("packet above largest size accepted");
  a_xfer_bad_ep: assert property (
    xferSeen ##0 xferEp == 3'h7 |=> xferRefuse_r)
    else $error("transfer to missing endpoint accepted");
  a_win_ep0_fold: assert property (
    winValid && winEp == 3'h0 |=> physValid_r &&
      physAddr_r == 12'($past(winAddr) & 16'h003f))
    else $error("endpoint zero window not folded onto its block");
  a_win_bad_ep: assert property (
    winValid && winEp == 3'h7 |=> !physValid_r)
    else $error("window lookup valid for missing endpoint");
endmodule

// file: testbench/ucfg_link_model.sv
// link engine model reporting finished transactions
`timescale 1ns/100ps
module ucfg_link_model
  import ucfg_pkg::*;
(
  input  logic               clk_sys,
  output logic               xferDone,
  output logic [EP_W-1:0]    xferEp,
  output logic               xferIn,
  output logic [LEN_W-1:0]   xferLen
);
  initial begin
    xferDone = 1'b0;
    xferEp = '0;
    xferIn = 1'b0;
    xferLen = '0;
  end

  // setup, data and status reported alike
  task automatic send(input logic [EP_W-1:0] ep, input logic din,
                      input logic [LEN_W-1:0] len);
    xferDone <= 1'b1;
    xferEp <= ep;
    xferIn <= din;
    xferLen <= len;
    @(posedge clk_sys);
    // released lines carry no stale report
    xferDone <= 1'b0;
    xferEp <= ~ep;
    xferIn <= ~din;
    xferLen <= ~len;
  endtask
endmodule

// file: testbench/tb.sv
// self-checking bench for the endpoint configuration block
`timescale 1ns/100ps
module tb;
  import ucfg_pkg::*;
  logic clk_sys = 1'b0, reset_n = 1'b0;
  logic [31:0] s_axi_awaddr = '0, s_axi_wdata = '0, s_axi_araddr = '0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, winValid = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, xferDone, xferIn, xferAccept_r, xferRefuse_r;
  logic physValid_r;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  logic [31:0] s_axi_rdata, rd;
  logic [EP_W-1:0] xferEp, winEp = '0;
  logic [LEN_W-1:0] xferLen;
  logic [WIN_AW-1:0] winAddr = '0;
  logic [RAM_AW-1:0] physAddr_r;
  logic [NUM_EP-1:0] epEvent_r;
  // cycles the master waits before raising bready or rready
  int fail_count = 0, n_tests = 0, lag = 0;
  logic [31:0] cfgA [5] = '{32'h10, 32'h20, 32'h20, 32'h30, 32'h30};
  logic [31:0] cfgD [5] = '{32'hae, 32'he0, 32'h0, 32'h1d7, 32'h197};
  logic [31:0] cfgE [5] = '{32'h800000ae, 32'he0, 32'h0, 32'h1d7,
                            32'h80000197};
  // {event[22:16], accept, in, ep[13:11], len[10:0]}
  logic [22:0] xv [10] = '{23'h28a00, 23'h20a01, 23'h21008, 23'ha9c00,
    23'ha1c01, 23'ha3800, 23'ha8008, 23'hac040, 23'ha8000, 23'ha4041};

  always #2.5 clk_sys = ~clk_sys;

  ucfg_endpoint_cfg ucfg_endpoint_cfg_i (.clk_sys, .reset_n,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .xferDone, .xferEp, .xferIn, .xferLen, .xferAccept_r,
    .xferRefuse_r, .winValid, .winEp, .winAddr, .physValid_r,
    .physAddr_r, .epEvent_r);
  ucfg_link_model ucfg_link_model_i (.clk_sys, .xferDone, .xferEp,
    .xferIn, .xferLen);

  // ****************************************
  // tasks
  // ****************************************
  task automatic chk(input string nm, input logic [31:0] got, exp);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic axw(input logic [31:0] a, d, output logic [1:0] r);
    int n;
    n = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= (lag == 0);
    do begin
      @(posedge clk_sys);
      n++;
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (n == lag) s_axi_bready <= 1'b1;
    end while (!(s_axi_bvalid && s_axi_bready));
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
    @(posedge clk_sys);
  endtask

  task automatic axr(input logic [31:0] a, output logic [31:0] d,
                     output logic [1:0] r);
    int n;
    n = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= (lag == 0);
    do begin
      @(posedge clk_sys);
      n++;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (n == lag) s_axi_rready <= 1'b1;
    end while (!(s_axi_rvalid && s_axi_rready));
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
    @(posedge clk_sys);
  endtask

  task automatic rdc(input logic [31:0] a, exp);
    axr(a, rd, resp);
    chk("register", rd, exp);
  endtask

  task automatic xf(input logic [22:0] v);
    ucfg_link_model_i.send(v[13:11], v[14], v[10:0]);
    @(negedge clk_sys);
    chk("accept", 32'(xferAccept_r), 32'(v[15]));
    chk("refuse", 32'(xferRefuse_r), 32'(!v[15]));
    @(negedge clk_sys);
    chk("event", 32'(epEvent_r), 32'(v[22:16]));
    @(posedge clk_sys);
  endtask

  task automatic win(input logic [2:0] ep, input logic [15:0] a,
                     input logic [11:0] exp, input logic v);
    winValid <= 1'b1;
    winEp <= ep;
    winAddr <= a;
    @(posedge clk_sys);
    winValid <= 1'b0;
    winAddr <= ~a;
    @(negedge clk_sys);
    chk("window valid", 32'(physValid_r), 32'(v));
    if (v) chk("window addr", 32'(physAddr_r), 32'(exp));
    @(posedge clk_sys);
  endtask

  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // ****************************************
  // tests
  // ****************************************
  initial begin
    repeat (2) @(posedge clk_sys);
    reset_n <= 1'b1;
    @(posedge clk_sys);
    rdc(32'h00, 32'h80000043);
    rdc(32'h04, 32'h0);
    for (int i = 0; i < 5; i++) begin
      axw(cfgA[i], cfgD[i], resp);
      rdc(cfgA[i], cfgE[i]);
    end
    s_axi_wstrb <= 4'h1;
    axw(32'h30, 32'h297, resp);
    s_axi_wstrb <= 4'hf;
    rdc(32'h30, 32'h80000197);
    axw(32'h00, 32'h0, resp);
    rdc(32'h00, 32'h80000043);
    axr(32'h70, rd, resp);
    chk("read resp", 32'(resp), 32'(RESP_SLVERR));
    chk("read data", rd, 32'h0);
    axw(32'h80, 32'h1, resp);
    chk("write resp", 32'(resp), 32'(RESP_SLVERR));
    axw(32'h08, 32'h1, resp);
    axw(32'h18, 32'h5, resp);
    axw(32'h38, 32'hb, resp);
    rdc(32'h18, 32'h0);
    rdc(32'h14, 32'h5);
    lag = 3;
    axw(32'h14, 32'h5, resp);
    chk("write resp", 32'(resp), 32'(RESP_OKAY));
    rdc(32'h14, 32'h5);
    lag = 0;
    foreach (xv[i]) xf(xv[i]);
    rdc(32'h3c, 32'h12);
    axw(32'h3c, 32'h4, resp);
    rdc(32'h3c, 32'h02);
    rdc(32'h1c, 32'h1);
    axw(32'h1c, 32'h1, resp);
    rdc(32'h1c, 32'h0);
    @(negedge clk_sys);
    chk("event", 32'(epEvent_r), 32'h08);
    @(posedge clk_sys);
    win(3'h0, 16'h1234, 12'h034, 1'b1);
    win(3'h1, 16'h1234, 12'h274, 1'b1);
    win(3'h3, 16'hffff, 12'hc3f, 1'b1);
    win(3'h2, 16'h0010, 12'h0, 1'b0);
    win(3'h7, 16'h0010, 12'h0, 1'b0);
    give_verdict();
  end

  initial begin
    repeat (5000) @(posedge clk_sys);
    fail_count++;
    give_verdict();
  end
endmodule

bind ucfg_endpoint_cfg ucfg_cfg_assertions ucfg_cfg_assertions_i (
  .clk_sys, .reset_n, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid,
  .s_axi_rready, .xferDone, .xferEp, .xferLen, .xferAccept_r,
  .xferRefuse_r, .winValid, .winEp, .winAddr, .physValid_r, .physAddr_r);
